// [design/gpb_pkg.sv]
// package: constants and carrier types for the general-purpose bus controller
// Functional notes
// R1: each interrupt input routes to any channel or NMI
// R2: peripheral raises its interrupt request when needing service
// R3: per-input setting inverts sensed interrupt polarity
// R4: wide select early makes a 16-bit memory cycle
// R5: read strobe marks memory read; device drives data
// R6: write strobe marks memory write; device latches data
// R7: ready low inserts wait states until high
// R8: ready line driven only by open-drain peripherals
// R9: bus reset output resets all attached devices
// R10: terminal count asserted on final DMA transfer
// R11: byte-high enable when upper byte lane used
// R12: buffer enable on external accesses, never internal echo
// R13: without wide select, 8-bit cycle on low lane
`default_nettype none
package gpb_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SETUP_NS = 30;
	localparam int unsigned STROBE_MIN_NS = 20;
	localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 3;
	localparam logic [2:0] SETUP_LOAD = 3'(SETUP_CYC - 1);
	localparam logic [2:0] STROBE_LOAD = 3'(STROBE_CYC - 1);
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned IRQ_N = 11;
	localparam int unsigned CHAN_N = 15;
	localparam int unsigned ROUTE_W = 4;
	localparam logic [3:0] ROUTE_NMI = 4'hF;
	localparam logic [7:0] HIGH_FILL = 8'h00;

	typedef enum logic [1:0] {
		GPB_IDLE = 2'b00,
		GPB_SETUP = 2'b01,
		GPB_STROBE = 2'b10,
		GPB_RECOV = 2'b11
	} gpb_state_t;

	typedef struct packed {
		logic [23:0] addr;
		logic write;
		logic want16;
		logic internal;
		logic dma_last;
		logic [15:0] wdata;
	} gpb_req_t;

	typedef struct packed {
		logic [15:0] rdata;
		logic wide;
	} gpb_resp_t;
endpackage
`default_nettype wire

// [design/gpb_irq_route.sv]
// module: interrupt input synchroniser, polarity inversion and routing
`default_nettype none
module gpb_irq_route (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// pins and configuration
	input wire logic [10:0] ext_irq_in,
	input wire logic [10:0] irq_invert_in,
	input wire logic [10:0][3:0] irq_route_in,
	// routed requests
	output logic [14:0] irq_chan_out,
	output logic nmi_out
);
	logic [10:0] irq_s1;
	logic [10:0] irq_s2;
	logic [10:0] irq_level;

	function automatic logic [10:0] route_hit(input logic [10:0][3:0] routes, input logic [3:0] code);
		logic [10:0] hit;
		hit = '0;
		for (int i = 0; i < gpb_pkg::IRQ_N; i++) begin
			hit[i] = (routes[i] == code);
		end
		return hit;
	endfunction

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			irq_s1 <= '0;
			irq_s2 <= '0;
		end else begin
			irq_s1 <= ext_irq_in;
			irq_s2 <= irq_s1;
		end
	end

	assign irq_level = irq_s2 ^ irq_invert_in; // R3

	genvar c;
	generate
		for (c = 0; c < gpb_pkg::CHAN_N; c++) begin : g_chan
			always_ff @(posedge clk_in) begin
				if (!resetn_in) begin
					irq_chan_out[c] <= 1'b0;
				end else begin
					irq_chan_out[c] <= |(irq_level & route_hit(irq_route_in, 4'(c))); // R1
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			nmi_out <= 1'b0;
		end else begin
			nmi_out <= |(irq_level & route_hit(irq_route_in, gpb_pkg::ROUTE_NMI)); // R1
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	irq_invert_a: assert property ((irq_s2[10] != irq_invert_in[10]) && irq_route_in[10] == gpb_pkg::ROUTE_NMI
		|=> nmi_out) else $error("inverted request not seen as asserted"); // R3
	irq_route_a: assert property (irq_level[1] && irq_route_in[1] != gpb_pkg::ROUTE_NMI
		|=> irq_chan_out[$past(irq_route_in[1])]) else $error("request not routed to its channel"); // R1
endmodule
`default_nettype wire

// [design/gpb_ctrl.sv]
// module: general-purpose bus memory cycle controller
`default_nettype none
module gpb_ctrl (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// internal request and answer
	input wire logic req_valid_in,
	input wire gpb_pkg::gpb_req_t req_in,
	output logic req_ready_out,
	output logic resp_valid_out,
	output gpb_pkg::gpb_resp_t resp_out,
	input wire logic bus_reset_req_in,
	// interrupt configuration and routed requests
	input wire logic [10:0] irq_invert_in,
	input wire logic [10:0][3:0] irq_route_in,
	output logic [14:0] irq_chan_out,
	output logic nmi_out,
	// bus pins
	output logic [23:0] addr_out,
	output logic [15:0] data_out,
	output logic data_oe_out,
	input wire logic [15:0] data_in,
	output logic mem_read_strobe_out,
	output logic mem_write_strobe_out,
	output logic byte_high_enable_out,
	output logic data_buffer_oe_out,
	output logic bus_reset_out,
	output logic dma_terminal_count_out,
	input wire logic mem_wide_select_in,
	input wire logic bus_ready_in,
	input wire logic [10:0] ext_irq_in
);
	gpb_pkg::gpb_state_t state;
	gpb_pkg::gpb_req_t cur;
	logic [2:0] cnt;
	logic wide_cyc;
	logic rdy_s1;
	logic rdy;
	logic wide_s1;
	logic wide_s;
	logic strobe_done;

	gpb_irq_route u_irq (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.ext_irq_in(ext_irq_in),
		.irq_invert_in(irq_invert_in),
		.irq_route_in(irq_route_in),
		.irq_chan_out(irq_chan_out),
		.nmi_out(nmi_out)
	);

	// pin synchronisers
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rdy_s1 <= 1'b1;
			rdy <= 1'b1;
			wide_s1 <= 1'b0;
			wide_s <= 1'b0;
		end else begin
			rdy_s1 <= bus_ready_in;
			rdy <= rdy_s1;
			wide_s1 <= mem_wide_select_in;
			wide_s <= wide_s1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			bus_reset_out <= 1'b1;
		end else begin
			bus_reset_out <= bus_reset_req_in; // R9
		end
	end

	assign req_ready_out = (state == gpb_pkg::GPB_IDLE) && !bus_reset_out;
	assign strobe_done = (state == gpb_pkg::GPB_STROBE) && (cnt == '0) && rdy; // R7

	// cycle sequencer
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state <= gpb_pkg::GPB_IDLE;
			cnt <= '0;
		end else begin
			case (state)
				gpb_pkg::GPB_IDLE: begin
					if (req_valid_in && req_ready_out) begin
						state <= gpb_pkg::GPB_SETUP;
						cnt <= gpb_pkg::SETUP_LOAD;
					end
				end
				gpb_pkg::GPB_SETUP: begin
					if (cnt == '0) begin
						state <= gpb_pkg::GPB_STROBE;
						cnt <= gpb_pkg::STROBE_LOAD;
					end else begin
						cnt <= cnt - 3'h1;
					end
				end
				gpb_pkg::GPB_STROBE: begin
					if (cnt != '0) begin
						cnt <= cnt - 3'h1;
					end else if (rdy) begin
						state <= gpb_pkg::GPB_RECOV; // R7
					end
				end
				gpb_pkg::GPB_RECOV: begin
					state <= gpb_pkg::GPB_IDLE;
				end
				default: begin
					state <= gpb_pkg::GPB_IDLE;
				end
			endcase
		end
	end

	// request latch and bus address and write data
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			cur <= '0;
			addr_out <= '0;
			data_out <= '0;
		end else if (req_valid_in && req_ready_out) begin
			cur <= req_in;
			addr_out <= req_in.addr;
			data_out <= req_in.wdata;
		end
	end

	// width decision at end of setup
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			wide_cyc <= 1'b0;
		end else if (state == gpb_pkg::GPB_SETUP && cnt == '0) begin
			wide_cyc <= cur.want16 && wide_s; // R4 R13
		end
	end

	// answer
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			resp_valid_out <= 1'b0;
			resp_out <= '0;
		end else begin
			resp_valid_out <= strobe_done;
			if (strobe_done) begin
				resp_out.wide <= wide_cyc;
				if (!cur.write) begin
					resp_out.rdata <= wide_cyc ? data_in : {gpb_pkg::HIGH_FILL, data_in[7:0]}; // R13
				end
			end
		end
	end

	assign mem_read_strobe_out = (state == gpb_pkg::GPB_STROBE) && !cur.write; // R5
	assign mem_write_strobe_out = (state == gpb_pkg::GPB_STROBE) && cur.write; // R6
	assign data_oe_out = cur.write && (state == gpb_pkg::GPB_SETUP || state == gpb_pkg::GPB_STROBE);
	assign byte_high_enable_out = (state == gpb_pkg::GPB_STROBE) && wide_cyc; // R11
	assign data_buffer_oe_out = (state != gpb_pkg::GPB_IDLE) && !cur.internal; // R12
	assign dma_terminal_count_out = (state == gpb_pkg::GPB_STROBE) && cur.dma_last; // R10

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence setup_end_wide;
		state == gpb_pkg::GPB_SETUP && cnt == '0 && cur.want16 && wide_s;
	endsequence
	sequence enter_strobe;
		state == gpb_pkg::GPB_STROBE;
	endsequence
	sequence take_ext;
		req_valid_in && req_ready_out && !req_in.internal;
	endsequence
	sequence take_int;
		req_valid_in && req_ready_out && req_in.internal;
	endsequence
	sequence take_dma;
		req_valid_in && req_ready_out && req_in.dma_last;
	endsequence

	strobe_excl_a: assert property (!(mem_read_strobe_out && mem_write_strobe_out))
		else $error("read and write strobes together"); // R5
	read_strobe_a: assert property (req_valid_in && req_ready_out && !req_in.write |-> ##4 mem_read_strobe_out [*2])
		else $error("read strobe missing after setup"); // R5
	write_strobe_a: assert property (req_valid_in && req_ready_out && req_in.write |-> ##4 mem_write_strobe_out [*2])
		else $error("write strobe missing after setup"); // R6
	wait_hold_a: assert property (state == gpb_pkg::GPB_STROBE && cnt == '0 && !rdy
		|=> state == gpb_pkg::GPB_STROBE && !resp_valid_out) else $error("cycle ended while not ready"); // R7
	ready_finish_a: assert property (strobe_done |=> resp_valid_out ##1 state == gpb_pkg::GPB_IDLE)
		else $error("cycle not ended on ready"); // R7
	wide_cycle_a: assert property (setup_end_wide ##1 enter_strobe |-> byte_high_enable_out)
		else $error("wide cycle without high byte enable"); // R4 R11
	narrow_cycle_a: assert property (resp_valid_out && !resp_out.wide && !cur.write
		|-> resp_out.rdata[15:8] == gpb_pkg::HIGH_FILL) else $error("narrow read used upper lane"); // R13
	buffer_oe_a: assert property (data_buffer_oe_out |-> !cur.internal && state != gpb_pkg::GPB_IDLE)
		else $error("buffer enable on internal access"); // R12
	term_count_a: assert property (dma_terminal_count_out |-> cur.dma_last && state == gpb_pkg::GPB_STROBE)
		else $error("terminal count outside final transfer"); // R10
	bus_reset_a: assert property (bus_reset_req_in |=> bus_reset_out && !req_ready_out)
		else $error("bus reset not driven"); // R9
	buffer_ext_a: assert property (take_ext |=> data_buffer_oe_out [*6])
		else $error("buffer enable dropped in external access"); // R12
	buffer_int_a: assert property (take_int |=> !data_buffer_oe_out [*6])
		else $error("buffer enable on internal access"); // R12
	term_take_a: assert property (take_dma |-> ##4 dma_terminal_count_out [*2])
		else $error("terminal count missing on final transfer"); // R10
	narrow_bhe_a: assert property (state == gpb_pkg::GPB_SETUP && cnt == '0 && !(cur.want16 && wide_s)
		|=> !byte_high_enable_out [*2]) else $error("narrow cycle drove high byte enable"); // R11 R13
	bhe_strobe_a: assert property (byte_high_enable_out |-> mem_read_strobe_out || mem_write_strobe_out)
		else $error("high byte enable outside a strobe"); // R11
	write_data_a: assert property (mem_write_strobe_out |-> data_oe_out && data_out == cur.wdata)
		else $error("write data not driven under strobe"); // R6
	read_capture_a: assert property (strobe_done && !cur.write && wide_cyc |=> resp_out.rdata == $past(data_in))
		else $error("wide read data not captured"); // R4 R5
	read_len_a: assert property ($rose(mem_read_strobe_out) |-> mem_read_strobe_out [*2])
		else $error("read strobe shorter than minimum"); // R5
	write_len_a: assert property ($rose(mem_write_strobe_out) |-> mem_write_strobe_out [*2])
		else $error("write strobe shorter than minimum"); // R6
	data_oe_read_a: assert property (mem_read_strobe_out |-> !data_oe_out)
		else $error("write data driven during read"); // R5
endmodule
`default_nettype wire

// [tb/gpb_mem_model.sv]
// memory peripheral model for the general-purpose bus
`default_nettype none
module gpb_mem_model (
	// clock and bus reset
	input wire logic clk_in,
	input wire logic bus_reset_in,
	// cycle strobes and data
	input wire logic sel_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out,
	// sizing and wait control
	input wire logic wide_en_in,
	input wire logic [3:0] waits_in,
	output logic wide_out,
	output logic pull_low_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem;
	logic [3:0] cnt;
	always_ff @(posedge clk_in) begin
		if (bus_reset_in) begin
			mem <= 16'hA55A;
			cnt <= 4'h0;
		end else begin
			if (wr_in)
				mem <= wdata_in;
			cnt <= sel_in ? cnt + 4'h1 : 4'h0;
		end
	end
	// released data shows the inverse, never the last value
	assign rdata_out = (rd_in && sel_in) ? mem : ~mem;
	assign wide_out = wide_en_in && sel_in;
	// open drain: only pulls low, the bench adds the pull-up
	assign pull_low_out = sel_in && (cnt < waits_in);
endmodule
`default_nettype wire

// [tb/gpb_ctrl_bench.sv]
// self-checking bench for the bus memory cycle controller
`default_nettype none
module gpb_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic req_valid_in = 1'b0;
	gpb_pkg::gpb_req_t req_in = '0;
	logic bus_reset_req_in = 1'b0;
	logic [10:0] irq_invert_in = '0;
	logic [10:0][3:0] irq_route_in = '0;
	logic [10:0] ext_irq_in = '0;
	logic wide_en = 1'b0;
	logic [3:0] waits = 4'h0;
	logic req_ready_out, resp_valid_out, data_oe_out, rd, wr, bhe, dboe, bus_reset_out, tc, nmi_out;
	gpb_pkg::gpb_resp_t resp_out;
	logic [14:0] irq_chan_out;
	logic [23:0] addr_out;
	logic [15:0] data_out, data_in;
	logic wide_sel, pull_low;
	int errors = 0;
	int check_count = 0;
	int lat;
	logic [5:0] seen;
	always #5 clk_in = ~clk_in;
	gpb_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in), .req_in(req_in),
		.req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out), .resp_out(resp_out),
		.bus_reset_req_in(bus_reset_req_in), .irq_invert_in(irq_invert_in), .irq_route_in(irq_route_in),
		.irq_chan_out(irq_chan_out), .nmi_out(nmi_out), .addr_out(addr_out), .data_out(data_out),
		.data_oe_out(data_oe_out), .data_in(data_in), .mem_read_strobe_out(rd), .mem_write_strobe_out(wr),
		.byte_high_enable_out(bhe), .data_buffer_oe_out(dboe), .bus_reset_out(bus_reset_out),
		.dma_terminal_count_out(tc), .mem_wide_select_in(wide_sel), .bus_ready_in(!pull_low),
		.ext_irq_in(ext_irq_in));
	gpb_mem_model i_mem (.clk_in(clk_in), .bus_reset_in(bus_reset_out), .sel_in(dboe), .rd_in(rd), .wr_in(wr),
		.wdata_in(data_out), .rdata_out(data_in), .wide_en_in(wide_en), .waits_in(waits),
		.wide_out(wide_sel), .pull_low_out(pull_low));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one memory cycle; seen collects {data_oe, rd, wr, bhe, tc, dboe}
	task automatic run_cycle(input logic w, input logic w16, input logic intl, input logic dma, input logic [15:0] wd);
		int n;
		n = 0;
		seen = '0;
		@(posedge clk_in) #1;
		req_in = '{24'h012345, w, w16, intl, dma, wd};
		req_valid_in = 1'b1;
		while (req_ready_out !== 1'b1) begin
			@(posedge clk_in) #1;
			if (++n > 50) begin
				errors++;
				tally_and_finish();
			end
		end
		@(posedge clk_in) #1;
		req_valid_in = 1'b0;
		lat = 0;
		while (resp_valid_out !== 1'b1) begin
			seen |= {data_oe_out, rd, wr, bhe, tc, dboe};
			@(posedge clk_in) #1;
			if (++lat > 60) begin
				errors++;
				tally_and_finish();
			end
		end
	endtask
	task automatic t_write16();
		wide_en = 1'b1;
		run_cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'hC3E1);
		check("wr seen", 16'h0001, {15'h0, seen[3]});
		check("rd seen", 16'h0000, {15'h0, seen[4]});
		check("bhe seen", 16'h0001, {15'h0, seen[2]});
		check("dboe seen", 16'h0001, {15'h0, seen[0]});
		check("latency", 16'(gpb_pkg::SETUP_CYC + gpb_pkg::STROBE_CYC), 16'(lat));
		check("data_oe seen", 16'h0001, {15'h0, seen[5]});
		check("addr low", 16'h2345, addr_out[15:0]);
		check("addr high", 16'h0001, {8'h0, addr_out[23:16]});
		$display("done write16");
	endtask
	task automatic t_read(input logic wd, input logic [15:0] exp);
		wide_en = wd;
		run_cycle(1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
		check("rdata", exp, resp_out.rdata);
		check("wide", {15'h0, wd}, {15'h0, resp_out.wide});
		check("bhe seen", {15'h0, wd}, {15'h0, seen[2]});
		check("rd seen", 16'h0001, {15'h0, seen[4]});
		check("data_oe seen", 16'h0000, {15'h0, seen[5]});
		$display("done read wide=%0d", wd);
	endtask
	task automatic t_wait();
		wide_en = 1'b1;
		waits = 4'h6;
		run_cycle(1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
		waits = 4'h0;
		check("extended", 16'h0001, {15'h0, lat > int'(gpb_pkg::SETUP_CYC + gpb_pkg::STROBE_CYC)});
		check("rdata", 16'hC3E1, resp_out.rdata);
		$display("done wait");
	endtask
	task automatic t_dma_internal();
		run_cycle(1'b0, 1'b0, 1'b1, 1'b1, 16'h0);
		check("tc seen", 16'h0001, {15'h0, seen[1]});
		check("dboe seen", 16'h0000, {15'h0, seen[0]});
		$display("done dma internal");
	endtask
	task automatic t_bus_reset();
		@(posedge clk_in) #1;
		bus_reset_req_in = 1'b1;
		@(posedge clk_in) #1;
		check("bus reset", 16'h0001, {15'h0, bus_reset_out});
		check("ready", 16'h0000, {15'h0, req_ready_out});
		bus_reset_req_in = 1'b0;
		t_read(1'b1, 16'hA55A);
		$display("done bus reset");
	endtask
	task automatic t_irq();
		logic [10:0] pins [3];
		logic [10:0] lv;
		pins = '{11'h000, 11'h7FF, 11'h0F3};
		irq_invert_in = 11'h555;
		for (int i = 0; i < 10; i++) irq_route_in[i] = 4'(14 - i);
		irq_route_in[10] = gpb_pkg::ROUTE_NMI;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_in) #1;
			ext_irq_in = pins[k];
			repeat (3) @(posedge clk_in);
			#1;
			lv = pins[k] ^ 11'h555;
			for (int i = 0; i < 10; i++) check("chan", {15'h0, lv[i]}, {15'h0, irq_chan_out[14 - i]});
			check("low chans", 16'h0000, {11'h0, irq_chan_out[4:0]});
			check("nmi", {15'h0, lv[10]}, {15'h0, nmi_out});
		end
		$display("done irq");
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		t_write16();
		t_read(1'b1, 16'hC3E1);
		t_read(1'b0, 16'h00E1);
		t_wait();
		t_dma_internal();
		t_bus_reset();
		t_irq();
		tally_and_finish();
	end
endmodule
`default_nettype wire
